// ### verilog/fss_pkg.sv
package fss_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_FREQ_HZ       = 50_000_000;
   localparam int RST_PULSE_US      = 1000;
   localparam int WD_PERIOD_MS      = 256;
   localparam int BUS_IDLE_MS       = 8000;
   localparam int RST_PULSE_CYC     = RST_PULSE_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int WD_PERIOD_CYC     = WD_PERIOD_MS * (CLK_FREQ_HZ / 1000);
   localparam int BUS_IDLE_CYC      = BUS_IDLE_MS * (CLK_FREQ_HZ / 1000);
   localparam int WD_FAIL_ESCALATE  = 8;

   // ------------------------------------------------------------
   // Safe-mode codes
   // ------------------------------------------------------------
   localparam logic [2:0] SW_CODE_KEEP     = 3'h7;
   localparam logic [2:0] SW_CODE_BUS_IDLE = 3'h6;
   localparam logic [2:0] SW_CODE_PIN_LOW  = 3'h5;
   localparam logic [2:0] SW_CODE_COMBINED = 3'h4;

   // Resistor class from the debug_select_pin comparator
   localparam logic [1:0] RES_CLASS_LOW = 2'h0;
   localparam logic [1:0] RES_CLASS_15K = 2'h1;
   localparam logic [1:0] RES_CLASS_33K = 2'h2;
   localparam logic [1:0] RES_CLASS_68K = 2'h3;

   localparam logic [15:0] CMD_RELEASE_A = 16'hdd00;
   localparam logic [15:0] CMD_RELEASE_B = 16'hdd80;

   localparam int WD_FIRST_PULSE_BIT = 4;

   typedef enum logic [1:0] {
      MODE_KEEP,
      MODE_BUS_IDLE_OFF,
      MODE_PIN_LOW_OFF,
      MODE_COMBINED_OFF
   } fss_mode_type;

   typedef struct packed {
      logic        valid;
      logic [15:0] word;
   } fss_cmd_type;

   typedef struct packed {
      logic can_activity;
      logic lin_activity;
      logic bus_idle;
   } fss_bus_type;

endpackage

// ### verilog/fss_supervisor.sv
// ----------------------------------------------------------------
// Overview of operation
// - Sample debug resistor at init-to-normal transition
// - Resistor class maps to safe-mode code
// - Software code overrides resistor selection
// - Fail-safe output driven low when asserted
// - Keep mode holds supply until recovery
// - Bus-idle mode: supply off after 8 s
// - Pin-low mode: supply off on low input
// - Combined: idle timeout and low input
// - Low detection uses high-to-low transition
// - Wake from supply-off enters reset, output stays
// - Wakes: CAN, LIN, enabled input high
// - Output held until release command clears
// - Watchdog fault at first or second pulse
// - Supply low asserts output with reset
// - Clamped reset line enters safe state
// - Missing refresh: 1 ms pulse every 256 ms
// - Eight consecutive failures flag escalation
// - Recovery needs reset, supply, refresh good
// ----------------------------------------------------------------
`timescale 1ns/1ps

module fss_supervisor
   import fss_pkg::*;
#(
   parameter int RST_PULSE_CYCLES = RST_PULSE_CYC,
   parameter int WD_PERIOD_CYCLES = WD_PERIOD_CYC,
   parameter int BUS_IDLE_CYCLES  = BUS_IDLE_CYC
)
(
   // Clock and reset
   input  wire logic        CORE_CLK_I,
   input  wire logic        RESET_N_I,
   input  wire logic        CLK_EN_I,
   // Mode and configuration
   input  wire logic        INIT_DONE_I,
   input  wire logic [1:0]  DEBUG_SELECT_PIN_I,
   input  wire logic        SW_CODE_WR_I,
   input  wire logic [2:0]  SW_CODE_I,
   input  wire logic        WD_CFG_WR_I,
   input  wire logic [7:0]  WD_CFG_I,
   input  wire logic        IO_WAKE_EN_I,
   // Controller traffic
   input  fss_cmd_type      CMD_I,
   input  wire logic        WD_REFRESH_OK_I,
   // Monitored pins and analog flags
   input  wire logic        VDD_LOW_I,
   input  wire logic        RESET_LINE_I,
   input  wire logic        WAKE_INPUT_I,
   input  fss_bus_type      BUS_I,
   // Outputs
   output logic             SAFE_N_O,
   output logic             VDD_ON_O,
   output logic             RESET_N_O,
   output logic             SAFE_STATE_O,
   output logic             WD_ESCALATE_O,
   output logic [1:0]       MODE_O
);

   // ------------------------------------------------------------
   // Reset release and input synchronisers
   // ------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic       rst_n;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
         rst_sync_r <= 2'h0;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_n = rst_sync_r[1];

   localparam int NSYNC = 7;
   logic [NSYNC-1:0] raw_in;
   logic [NSYNC-1:0] meta_r;
   logic [NSYNC-1:0] sync_r;

   assign raw_in = {DEBUG_SELECT_PIN_I, VDD_LOW_I, RESET_LINE_I, WAKE_INPUT_I,
                    BUS_I.can_activity, BUS_I.lin_activity};

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge CORE_CLK_I or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_r[gi] <= 1'b0;
               sync_r[gi] <= 1'b0;
            end
            else if (CLK_EN_I)
            begin
               meta_r[gi] <= raw_in[gi];
               sync_r[gi] <= meta_r[gi];
            end
         end
      end
   endgenerate

   logic [1:0] dbg_res;
   logic       vdd_low;
   logic       rst_line;
   logic       wake_in;
   logic       can_act;
   logic       lin_act;
   assign dbg_res  = sync_r[6:5];
   assign vdd_low  = sync_r[4];
   assign rst_line = sync_r[3];
   assign wake_in  = sync_r[2];
   assign can_act  = sync_r[1];
   assign lin_act  = sync_r[0];

   logic bus_idle_r;
   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         bus_idle_r <= 1'b0;
      else if (CLK_EN_I)
         bus_idle_r <= BUS_I.bus_idle;
   end

   // ------------------------------------------------------------
   // Safe-mode code selection
   // ------------------------------------------------------------
   function automatic fss_mode_type res_to_mode(input logic [1:0] cls);
      case (cls)
         RES_CLASS_LOW: res_to_mode = MODE_KEEP;
         RES_CLASS_15K: res_to_mode = MODE_BUS_IDLE_OFF;
         RES_CLASS_33K: res_to_mode = MODE_PIN_LOW_OFF;
         default:       res_to_mode = MODE_COMBINED_OFF;
      endcase
   endfunction

   function automatic fss_mode_type sw_to_mode(input logic [2:0] code,
                                                input fss_mode_type cur);
      case (code)
         SW_CODE_KEEP:     sw_to_mode = MODE_KEEP;
         SW_CODE_BUS_IDLE: sw_to_mode = MODE_BUS_IDLE_OFF;
         SW_CODE_PIN_LOW:  sw_to_mode = MODE_PIN_LOW_OFF;
         SW_CODE_COMBINED: sw_to_mode = MODE_COMBINED_OFF;
         default:          sw_to_mode = cur;
      endcase
   endfunction

   fss_mode_type mode_r;
   logic         sensed_r;
   logic         init_d_r;
   logic         init_rise;
   assign init_rise = INIT_DONE_I && !init_d_r;

   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_r   <= MODE_KEEP;
         sensed_r <= 1'b0;
         init_d_r <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         init_d_r <= INIT_DONE_I;
         if (SW_CODE_WR_I)
            mode_r <= sw_to_mode(SW_CODE_I, mode_r);
         else if (init_rise && !sensed_r)
         begin
            mode_r   <= res_to_mode(dbg_res);
            sensed_r <= 1'b1;
         end
      end
   end

   logic wd_first_r;
   logic io_wake_arm_r;
   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         wd_first_r <= 1'b0;
      else if (CLK_EN_I && WD_CFG_WR_I)
         wd_first_r <= WD_CFG_I[WD_FIRST_PULSE_BIT];
   end

   // ------------------------------------------------------------
   // Watchdog reset pulse generator
   // ------------------------------------------------------------
   logic [31:0] wd_cnt_r;
   logic [3:0]  fail_cnt_r;
   logic        pulse_r;
   logic        period_end;
   logic        pulse_end;
   logic        pulse_start;

   assign period_end  = (wd_cnt_r == 32'(WD_PERIOD_CYCLES - 1));
   assign pulse_end   = (wd_cnt_r == 32'(RST_PULSE_CYCLES - 1));
   assign pulse_start = period_end && !WD_REFRESH_OK_I;

   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wd_cnt_r   <= 32'h0;
         fail_cnt_r <= 4'h0;
         pulse_r    <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         if (WD_REFRESH_OK_I)
         begin
            wd_cnt_r   <= 32'h0;
            fail_cnt_r <= 4'h0;
         end
         else if (period_end)
         begin
            wd_cnt_r <= 32'h0;
            pulse_r  <= 1'b1;
            if (fail_cnt_r != 4'(WD_FAIL_ESCALATE))
               fail_cnt_r <= fail_cnt_r + 4'h1;
         end
         else
            wd_cnt_r <= wd_cnt_r + 32'h1;
         if (pulse_r && pulse_end)
            pulse_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Fault detection and fail-safe output
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_RUN,
      ST_SAFE_ON,
      ST_SAFE_OFF,
      ST_WAKE_RESET
   } fss_state_type;

   fss_state_type safe_st_r;
   fss_state_type safe_st_nxt;

   logic       wd_fault;
   logic       fault_now;
   logic       release_cmd;
   logic       safe_r;
   logic       recovered;
   logic [2:0] clamp_r;
   logic       clamp;

   // Line low while we do not drive it low: held low from outside
   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         clamp_r <= 3'h0;
      else if (CLK_EN_I)
         clamp_r <= {clamp_r[1:0], !rst_line && RESET_N_O};
   end
   assign clamp = (&clamp_r) && !rst_line && RESET_N_O;

   assign wd_fault    = pulse_start &&
                        (wd_first_r ? (fail_cnt_r == 4'h0) : (fail_cnt_r == 4'h1));
   assign fault_now   = wd_fault || vdd_low || clamp;
   assign release_cmd = CMD_I.valid &&
                        (CMD_I.word == CMD_RELEASE_A || CMD_I.word == CMD_RELEASE_B);
   assign recovered   = rst_line && !vdd_low && WD_REFRESH_OK_I;

   // ------------------------------------------------------------
   // Safe-state sequencer
   // ------------------------------------------------------------
   logic [31:0]   idle_cnt_r;
   logic          idle_done;
   logic          wake_d_r;
   logic          low_seen_r;
   logic          wake_fall;
   logic          off_cond;
   logic          wake_evt;
   logic [31:0]   wrst_cnt_r;

   assign idle_done = (idle_cnt_r == 32'(BUS_IDLE_CYCLES));
   assign wake_fall = wake_d_r && !wake_in;

   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         idle_cnt_r    <= 32'h0;
         wake_d_r      <= 1'b0;
         low_seen_r    <= 1'b0;
         io_wake_arm_r <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         wake_d_r <= wake_in;
         if (safe_st_r == ST_RUN)
            io_wake_arm_r <= IO_WAKE_EN_I;
         if (safe_st_r != ST_SAFE_ON || !bus_idle_r)
            idle_cnt_r <= 32'h0;
         else if (!idle_done)
            idle_cnt_r <= idle_cnt_r + 32'h1;
         if (safe_st_r != ST_SAFE_ON)
            low_seen_r <= 1'b0;
         else if (wake_fall)
            low_seen_r <= 1'b1;
      end
   end

   always_comb
   begin
      case (mode_r)
         MODE_BUS_IDLE_OFF: off_cond = idle_done;
         MODE_PIN_LOW_OFF:  off_cond = low_seen_r || wake_fall;
         MODE_COMBINED_OFF: off_cond = idle_done && (low_seen_r || wake_fall);
         default:           off_cond = 1'b0;
      endcase
   end

   assign wake_evt = can_act || lin_act || (io_wake_arm_r && wake_in);

   always_comb
   begin
      safe_st_nxt = safe_st_r;
      case (safe_st_r)
         ST_RUN:
            if (fault_now)
               safe_st_nxt = ST_SAFE_ON;
         ST_SAFE_ON:
            if (recovered)
               safe_st_nxt = ST_RUN;
            else if (off_cond)
               safe_st_nxt = ST_SAFE_OFF;
         ST_SAFE_OFF:
            if (wake_evt)
               safe_st_nxt = ST_WAKE_RESET;
         ST_WAKE_RESET:
            if (wrst_cnt_r == 32'(RST_PULSE_CYCLES - 1))
               safe_st_nxt = ST_RUN;
         default:
            safe_st_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         safe_st_r <= ST_RUN;
         safe_r    <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         safe_st_r <= safe_st_nxt;
         if (fault_now || (safe_st_r == ST_SAFE_ON && !recovered))
            safe_r <= 1'b1;
         else if (release_cmd)
            safe_r <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
         wrst_cnt_r <= 32'h0;
      else if (CLK_EN_I)
         wrst_cnt_r <= (safe_st_r == ST_WAKE_RESET) ? wrst_cnt_r + 32'h1 : 32'h0;
   end

   // ------------------------------------------------------------
   // Registered outputs
   // ------------------------------------------------------------
   logic rst_req;
   assign rst_req = pulse_start || (pulse_r && !pulse_end) || vdd_low ||
                    (safe_st_nxt == ST_WAKE_RESET &&
                     wrst_cnt_r < 32'(RST_PULSE_CYCLES - 1));

   always_ff @(posedge CORE_CLK_I or negedge rst_n)
   begin
      if (!rst_n)
      begin
         SAFE_N_O      <= 1'b1;
         VDD_ON_O      <= 1'b1;
         RESET_N_O     <= 1'b0;
         SAFE_STATE_O  <= 1'b0;
         WD_ESCALATE_O <= 1'b0;
         MODE_O        <= 2'h0;
      end
      else if (CLK_EN_I)
      begin
         SAFE_N_O      <= !(safe_r || fault_now);
         VDD_ON_O      <= (safe_st_nxt != ST_SAFE_OFF);
         RESET_N_O     <= !rst_req;
         SAFE_STATE_O  <= (safe_st_nxt != ST_RUN);
         WD_ESCALATE_O <= (fail_cnt_r == 4'(WD_FAIL_ESCALATE));
         MODE_O        <= mode_r;
      end
   end

endmodule

// ### sim/fss_mcu_model.sv
`timescale 1ns/1ps
module fss_mcu_model
   import fss_pkg::*;
(
   // Clock and requests
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        refresh_req_i,
   input  wire logic        cmd_req_i,
   input  wire logic [15:0] cmd_word_i,
   // Towards the device
   output fss_cmd_type      cmd_o,
   output logic             refresh_o
);
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cmd_o     <= '0;
         refresh_o <= 1'b0;
      end
      else
      begin
         refresh_o   <= refresh_req_i;
         cmd_o.valid <= cmd_req_i;
         cmd_o.word  <= cmd_req_i ? cmd_word_i : ~cmd_o.word;
      end
   end
endmodule

// ### sim/fss_supervisor_chk.sv
`timescale 1ns/1ps
module fss_supervisor_chk
   import fss_pkg::*;
#(
   parameter int WD_PERIOD_CYCLES = 40
)
(
   // Clock and inputs
   input wire logic       CORE_CLK_I,
   input wire logic       RESET_N_I,
   input wire logic       INIT_DONE_I,
   input wire logic       SW_CODE_WR_I,
   input wire logic [2:0] SW_CODE_I,
   input wire logic       WD_REFRESH_OK_I,
   input fss_cmd_type     CMD_I,
   input wire logic       VDD_LOW_I,
   input wire logic       WAKE_INPUT_I,
   input fss_bus_type     BUS_I,
   // Outputs
   input wire logic       SAFE_N_O,
   input wire logic       VDD_ON_O,
   input wire logic       RESET_N_O,
   input wire logic       WD_ESCALATE_O,
   input wire logic [1:0] MODE_O
);
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   logic [3:0]  cause_r;
   logic [15:0] quiet_r;
   wire         code_ok = SW_CODE_WR_I && SW_CODE_I[2];
   wire         rel     = CMD_I.valid &&
                          (CMD_I.word == CMD_RELEASE_A || CMD_I.word == CMD_RELEASE_B);

   // Recent causes of a mode change, and cycles since the last refresh
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         cause_r <= '0;
         quiet_r <= '0;
      end
      else
      begin
         cause_r <= {cause_r[2:0], code_ok | $rose(INIT_DONE_I)};
         quiet_r <= WD_REFRESH_OK_I ? '0 : quiet_r + 16'(quiet_r != '1);
      end
   end

   AST_VDD_LOW_SAFE: assert property (
      $rose(VDD_LOW_I) ##1 VDD_LOW_I [*3] |-> ##[0:2] (!SAFE_N_O && !RESET_N_O))
      else $error("supply low without fail-safe and reset");
   AST_PIN_LOW_OFF: assert property (
      MODE_O == 2'h2 && !SAFE_N_O && VDD_ON_O && $fell(WAKE_INPUT_I) |-> ##[1:6] !VDD_ON_O)
      else $error("supply stayed on after input fall");
   AST_WAKE_RESET: assert property (
      !VDD_ON_O && $rose(BUS_I.can_activity) |-> ##[1:8] (VDD_ON_O && !RESET_N_O && !SAFE_N_O))
      else $error("wake did not restore supply into reset");
   AST_RELEASE_CAUSE: assert property (
      $rose(SAFE_N_O) |-> $past(rel) || $past(rel, 2) || $past(rel, 3))
      else $error("fail-safe released without command");
   AST_SW_CODE: assert property (
      code_ok |-> ##2 MODE_O == ~$past(SW_CODE_I[1:0], 2))
      else $error("software code not applied");
   AST_MODE_HELD: assert property (
      $changed(MODE_O) |-> |cause_r)
      else $error("mode changed without cause");
   AST_ESCALATE: assert property (
      $rose(WD_ESCALATE_O) |-> quiet_r >= 16'(7 * WD_PERIOD_CYCLES))
      else $error("escalation too early");
   AST_KEEP_SUPPLY: assert property (
      MODE_O == 2'h0 && !SAFE_N_O |-> VDD_ON_O)
      else $error("supply off in keep mode");
endmodule

// ### sim/fss_supervisor_tb.sv
`timescale 1ns/1ps
module fss_supervisor_tb;
   import fss_pkg::*;
   localparam int RP = 5;
   localparam int WP = 40;
   localparam int BI = 20;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        init_done = 1'b0;
   logic [1:0]  res_class = 2'h0;
   logic [3:0]  stb = 4'h0;
   logic [2:0]  sw_code = 3'h7;
   logic [7:0]  wd_cfg = 8'h0;
   logic        io_en = 1'b0;
   logic        vdd_low = 1'b0;
   logic        wake_in = 1'b0;
   logic        rst_line = 1'b1;
   logic        safe_state;
   logic [15:0] cmd_word = 16'h0;
   fss_bus_type bus = '0;
   fss_cmd_type cmd;
   logic        refresh;
   logic        safe_n;
   logic        vdd_on;
   logic        rst_out_n;
   logic        esc;
   logic [1:0]  mode;
   logic [31:0] seed = 32'haee9655b;
   int          errors = 0;
   int          samples_checked = 0;
   int          n;

   always #10 clk = ~clk;

   fss_mcu_model mcu (.clk_i(clk), .rst_n_i(rst_n), .refresh_req_i(stb[2]),
      .cmd_req_i(stb[3]), .cmd_word_i(cmd_word), .cmd_o(cmd), .refresh_o(refresh));

   fss_supervisor #(.RST_PULSE_CYCLES(RP), .WD_PERIOD_CYCLES(WP), .BUS_IDLE_CYCLES(BI)) dut (
      .CORE_CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1), .INIT_DONE_I(init_done),
      .DEBUG_SELECT_PIN_I(res_class), .SW_CODE_WR_I(stb[0]), .SW_CODE_I(sw_code),
      .WD_CFG_WR_I(stb[1]), .WD_CFG_I(wd_cfg), .IO_WAKE_EN_I(io_en), .CMD_I(cmd),
      .WD_REFRESH_OK_I(refresh), .VDD_LOW_I(vdd_low), .RESET_LINE_I(rst_line),
      .WAKE_INPUT_I(wake_in), .BUS_I(bus), .SAFE_N_O(safe_n), .VDD_ON_O(vdd_on),
      .RESET_N_O(rst_out_n), .SAFE_STATE_O(safe_state), .WD_ESCALATE_O(esc),
      .MODE_O(mode));

   // ------
   // Helpers
   // ------
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Strobes: 0 code write, 1 watchdog config, 2 refresh, 3 command
   task automatic strobe(input int b);
      stb[b] <= 1'b1;
      tick(1);
      stb[b] <= 1'b0;
      tick(3);
   endtask

   task automatic restart(input logic [1:0] c);
      rst_n <= 1'b0;
      init_done <= 1'b0;
      res_class <= c;
      tick(4);
      rst_n <= 1'b1;
      tick(6);
      init_done <= 1'b1;
      tick(6);
   endtask

   task automatic wait_lvl(ref logic s, input logic v);
      for (int i = 0; i < 600 && s !== v; i++)
         @(posedge clk);
      chk(16'(s), 16'(v));
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      #500000;
      errors++;
      conclude();
   end

   // ------
   // Scenarios
   // ------
   initial
   begin
      for (int k = 0; k < 4; k++)
      begin
         restart(2'(k));
         chk(16'(mode), 16'(k));
      end
      res_class <= 2'h1;
      tick(6);
      chk(16'(mode), 16'h3);
      chk(16'({safe_n, vdd_on}), 16'h3);
      for (int c = 7; c >= 0; c--)
      begin
         sw_code <= 3'(c);
         strobe(0);
         chk(16'(mode), c > 3 ? 16'(7 - c) : 16'h3);
      end
      $display("test modes done");
      restart(2'h0);
      seed = lfsr(seed);
      wd_cfg <= {seed[7:5], 1'b1, seed[3:0]};
      strobe(1);
      wait_lvl(rst_out_n, 1'b0);
      for (n = 0; n < 50 && rst_out_n === 1'b0; n++)
         tick(1);
      chk(16'(n), 16'(RP));
      chk(16'(safe_n), 16'h0);
      seed = lfsr(seed);
      cmd_word <= {1'b0, seed[14:0]};
      strobe(3);
      cmd_word <= CMD_RELEASE_A;
      strobe(3);
      chk(16'(safe_n), 16'h0);
      strobe(2);
      cmd_word <= CMD_RELEASE_B;
      strobe(3);
      chk(16'(safe_n), 16'h1);
      $display("test first pulse done");
      restart(2'h0);
      wd_cfg <= 8'h0;
      strobe(1);
      wait_lvl(rst_out_n, 1'b0);
      wait_lvl(rst_out_n, 1'b1);
      chk(16'(safe_n), 16'h1);
      wait_lvl(rst_out_n, 1'b0);
      tick(2);
      chk(16'({safe_n, esc}), 16'h0);
      wait_lvl(esc, 1'b1);
      $display("test second pulse done");
      restart(2'h0);
      strobe(2);
      vdd_low <= 1'b1;
      tick(6);
      chk(16'({safe_n, rst_out_n}), 16'h0);
      chk(16'(safe_state), 16'h1);
      tick(10);
      chk(16'(vdd_on), 16'h1);
      vdd_low <= 1'b0;
      tick(6);
      strobe(2);
      cmd_word <= CMD_RELEASE_A;
      strobe(3);
      chk(16'(safe_n), 16'h1);
      $display("test supply low done");
      restart(2'h0);
      strobe(2);
      rst_line <= 1'b0;
      tick(8);
      chk(16'({safe_n, safe_state}), 16'h1);
      rst_line <= 1'b1;
      tick(4);
      strobe(2);
      cmd_word <= CMD_RELEASE_B;
      strobe(3);
      chk(16'({safe_n, safe_state}), 16'h2);
      $display("test clamped reset done");
      restart(2'h2);
      wake_in <= 1'b1;
      io_en <= 1'b1;
      wd_cfg <= 8'h10;
      strobe(1);
      wait_lvl(safe_n, 1'b0);
      tick(6);
      chk(16'(vdd_on), 16'h1);
      wake_in <= 1'b0;
      tick(6);
      chk(16'(vdd_on), 16'h0);
      bus.can_activity <= 1'b1;
      wait_lvl(vdd_on, 1'b1);
      chk(16'({rst_out_n, safe_n}), 16'h0);
      bus.can_activity <= 1'b0;
      $display("test pin low done");
      restart(2'h1);
      strobe(1);
      wait_lvl(safe_n, 1'b0);
      bus.bus_idle <= 1'b1;
      tick(BI / 2);
      chk(16'(vdd_on), 16'h1);
      tick(BI);
      chk(16'(vdd_on), 16'h0);
      bus.bus_idle <= 1'b0;
      bus.lin_activity <= 1'b1;
      wait_lvl(vdd_on, 1'b1);
      bus.lin_activity <= 1'b0;
      $display("test bus idle done");
      restart(2'h3);
      wake_in <= 1'b1;
      strobe(1);
      wait_lvl(safe_n, 1'b0);
      bus.bus_idle <= 1'b1;
      tick(2 * BI);
      chk(16'(vdd_on), 16'h1);
      wake_in <= 1'b0;
      tick(6);
      chk(16'(vdd_on), 16'h0);
      wake_in <= 1'b1;
      wait_lvl(vdd_on, 1'b1);
      $display("test combined done");
      conclude();
   end
endmodule

bind fss_supervisor fss_supervisor_chk #(.WD_PERIOD_CYCLES(WD_PERIOD_CYCLES)) u_chk (.*);
